// ---- core/drive_inputs_consts.svh ----
// Constants for the drive terminal input routing block
`ifndef DRIVE_INPUTS_CONSTS_SVH
`define DRIVE_INPUTS_CONSTS_SVH

// Register byte offsets
`define REG_PROFILE     8'h00
`define REG_SETTINGS    8'h04
`define REG_STATUS      8'h08
`define REG_CONSOLE     8'h0C
`define REG_RAMP        8'h10
`define REG_RESTART     8'h14
`define REG_MAP_BASE    8'h40
// Reset values
`define PROFILE_RESET   3'h0
`define RAMP_RESET_S    16'h000A
`define OVR_RAMP_RESET  16'h000A
`define RESTART_RESET   8'h00
// Source code fields: bits 2:0 terminal, bits 4:3 sense
`define SRC_SEL_LSB     0
`define SRC_SENSE_LSB   3
// Settings register fields
`define SET_REVPERM_BIT 0
`define SET_CONRUN_BIT  1
`define SET_CONREV_BIT  2
`define SET_OVRRAMP_LSB 16
// Bus wait states before an answer
`define BUS_WAIT_CYCLES 2'h1

`endif

// ---- core/drive_inputs_pkg.sv ----
// Types for the drive terminal input routing block
`default_nettype none
package drive_inputs_pkg;

    // Terminal profile codes
    typedef enum logic [2:0] {
        PROF_STANDARD = 3'h0,
        PROF_HVAC     = 3'h1,
        PROF_POWERUP  = 3'h2,
        PROF_FWDREV   = 3'h3,
        PROF_MACH1    = 3'h4,
        PROF_MACH2    = 3'h5,
        PROF_MACH3    = 3'h6,
        PROF_CUSTOM   = 3'h7
    } profile_t;

    // Physical source choice
    typedef enum logic [2:0] {
        SRC_OFF   = 3'h0,
        SRC_T1    = 3'h1,
        SRC_T2    = 3'h2,
        SRC_T3    = 3'h3,
        SRC_T4    = 3'h4,
        SRC_EN    = 3'h5,
        SRC_ON    = 3'h6
    } src_sel_t;

    // Sense of an assigned source
    typedef enum logic [1:0] {
        SENSE_HIGH = 2'h0,
        SENSE_LOW  = 2'h1,
        SENSE_RISE = 2'h2,
        SENSE_FALL = 2'h3
    } sense_t;

    // One function's source assignment
    typedef struct packed {
        sense_t   sense;
        src_sel_t sel;
    } src_t;

    // Bus access state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WAIT = 2'h1,
        BUS_DONE = 2'h2
    } bus_state_t;

    // Drive command outputs
    typedef struct packed {
        logic        run;
        logic        reverse;
        logic        inching;
        logic        override_mode;
        logic        remote_ref;
        logic        trip_clear;
        logic        ref_up;
        logic        ref_down;
        logic        trip_mask;
        logic        restart_unlimited;
        logic [15:0] ramp_s;
    } drive_cmd_t;

endpackage : drive_inputs_pkg
`default_nettype wire

// ---- core/drive_run_command_inputs.sv ----
// Terminal input routing, run latch and command arbitration
`include "drive_inputs_consts.svh"
`default_nettype none
module drive_run_command_inputs
    import drive_inputs_pkg::*;
#(
    parameter int NUM_FUNCS = 12,  // Logical control functions
    parameter int NUM_TERMS = 4    // Physical input terminals
)(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [NUM_TERMS-1:0]  input_terminal,
    input  wire logic                  enable_terminal,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    output logic [1:0]                 avs_response,
    output drive_cmd_t                 drive_cmd
);

    // Function indices
    localparam int F_FWD_LATCH = 0;
    localparam int F_REV_LATCH = 1;
    localparam int F_PERMIT_N  = 2;
    localparam int F_FWD_HELD  = 3;
    localparam int F_REV_HELD  = 4;
    localparam int F_REF_UP    = 5;
    localparam int F_REF_DOWN  = 6;
    localparam int F_TRIP_CLR  = 7;
    localparam int F_OVERRIDE  = 8;
    localparam int F_INCH_FWD  = 9;
    localparam int F_INCH_REV  = 10;
    localparam int F_REMOTE    = 11;

    // Refuse sizes the logic cannot serve
    if (NUM_FUNCS != 12 || NUM_TERMS != 4)
    begin : g_size_check
        $error("drive_run_command_inputs serves 12 functions and 4 terminals");
    end

    // Whole module state
    typedef struct packed {
        logic [NUM_TERMS:0] sync1;      // First stage, terminals plus enable
        logic [NUM_TERMS:0] sync2;      // Second stage
        logic [NUM_TERMS:0] sync3;      // Third stage
        logic [NUM_TERMS:0] level;      // Agreed input levels
        logic [NUM_TERMS:0] level_d;    // Levels one cycle earlier
        profile_t           profile;    // Chosen terminal profile
        logic               rev_perm;   // Reverse permission
        logic               con_run;    // Console run command
        logic               con_rev;    // Console direction
        logic [15:0]        ovr_ramp;   // Override ramp seconds
        logic [15:0]        ramp;       // Normal ramp seconds
        logic [7:0]         restart;    // Auto restart count
        logic               latch_run;  // Run latch
        logic               latch_rev;  // Latched direction
        logic [15:0]        console_ref; // Console speed reference
        src_t [11:0]        map;        // Custom source table
        bus_state_t         bus;        // Bus answer state
        logic [31:0]        rdata;      // Read data
        logic [1:0]         resp;       // Bus response
        drive_cmd_t         cmd;        // Registered drive commands
    } state_t;

    state_t state_reg;   // Registered state
    state_t state_next;  // Next state

    // Source code from terminal, sense high
    function automatic src_t src(input src_sel_t s);
        src = '{sense: SENSE_HIGH, sel: s};
    endfunction : src

    // Evaluate one source under its sense
    function automatic logic eval_src(
        input src_t               s,
        input logic [NUM_TERMS:0] lv,
        input logic [NUM_TERMS:0] lv_d
    );
        logic now_v;
        logic old_v;
        now_v = 1'b0;
        old_v = 1'b0;
        case (s.sel)
            SRC_T1:  begin now_v = lv[0]; old_v = lv_d[0]; end
            SRC_T2:  begin now_v = lv[1]; old_v = lv_d[1]; end
            SRC_T3:  begin now_v = lv[2]; old_v = lv_d[2]; end
            SRC_T4:  begin now_v = lv[3]; old_v = lv_d[3]; end
            SRC_EN:  begin now_v = lv[4]; old_v = lv_d[4]; end
            SRC_ON:  begin now_v = 1'b1;  old_v = 1'b1;    end
            default: begin now_v = 1'b0;  old_v = 1'b0;    end
        endcase
        case (s.sense)
            SENSE_HIGH: eval_src = now_v;
            SENSE_LOW:  eval_src = (s.sel == SRC_OFF) ? 1'b0 : !now_v;
            SENSE_RISE: eval_src = now_v && !old_v;
            SENSE_FALL: eval_src = !now_v && old_v;
            default:    eval_src = 1'b0;
        endcase
    endfunction : eval_src

    // Profile routing table
    function automatic src_t [11:0] profile_map(input profile_t p, input src_t [11:0] custom);
        src_t [11:0] m;
        m = '{default: src(SRC_OFF)};
        case (p)
            PROF_STANDARD:
            begin
                m[F_FWD_LATCH] = src(SRC_T3);
                m[F_PERMIT_N]  = src(SRC_T2);
                m[F_TRIP_CLR]  = src(SRC_T1);
                m[F_REMOTE]    = src(SRC_T4);
            end
            PROF_HVAC:
            begin
                m[F_FWD_LATCH] = src(SRC_T2);
                m[F_PERMIT_N]  = src(SRC_T1);
                m[F_TRIP_CLR]  = src(SRC_EN);
                m[F_OVERRIDE]  = src(SRC_T3);
                m[F_REMOTE]    = src(SRC_T4);
            end
            PROF_POWERUP:
            begin
                m[F_FWD_LATCH] = src(SRC_EN);
                m[F_PERMIT_N]  = src(SRC_EN);
                m[F_TRIP_CLR]  = src(SRC_EN);
                m[F_REMOTE]    = src(SRC_EN);
            end
            PROF_FWDREV:
            begin
                m[F_FWD_LATCH] = src(SRC_T2);
                m[F_REV_LATCH] = src(SRC_T3);
                m[F_PERMIT_N]  = src(SRC_T1);
                m[F_REMOTE]    = src(SRC_T4);
            end
            PROF_MACH1:
            begin
                m[F_FWD_LATCH] = src(SRC_T2);
                m[F_PERMIT_N]  = src(SRC_T1);
                m[F_INCH_FWD]  = src(SRC_T3);
                m[F_REMOTE]    = src(SRC_T4);
            end
            PROF_MACH2:
            begin
                m[F_FWD_HELD]  = src(SRC_T1);
                m[F_REV_HELD]  = src(SRC_T2);
                m[F_INCH_FWD]  = src(SRC_T3);
                m[F_INCH_REV]  = src(SRC_T4);
                m[F_REMOTE]    = src(SRC_EN);
            end
            PROF_MACH3:
            begin
                m[F_FWD_LATCH] = src(SRC_T2);
                m[F_PERMIT_N]  = src(SRC_T1);
                m[F_REF_UP]    = src(SRC_T3);
                m[F_REF_DOWN]  = src(SRC_T4);
                m[F_REMOTE]    = src(SRC_EN);
            end
            // Custom uses the editable table
            PROF_CUSTOM: m = custom;
            default:     m = '{default: src(SRC_OFF)};
        endcase
        profile_map = m;
    endfunction : profile_map

    // Function states, routed by the chosen profile
    src_t [11:0]       routing;   // applied map
    logic [11:0]       func;      // Evaluated function inputs
    logic              bus_req;   // Bus request present
    logic              bus_wr;    // Write taken this cycle
    logic              map_hit;   // Address in custom table
    logic [3:0]        map_idx;   // Table entry index
    logic              ovr;       // Override active
    logic              fwd_req;   // Forward request
    logic              rev_req;   // Reverse request
    logic              inch;      // Inching active
    logic [31:0]       wmask;     // Byte enable mask
    drive_cmd_t        cmd_comb;  // Commands before the register

    // Combinational routing and evaluation
    always_comb
    begin
        routing = profile_map(state_reg.profile, state_reg.map);
        for (int i = 0; i < 12; i++)
        begin
            func[i] = eval_src(routing[i], state_reg.level, state_reg.level_d);
        end
    end

    // Next state logic
    always_comb
    begin
        state_next = state_reg;
        // Three stage sync, change when stages two and three agree
        state_next.sync1   = {enable_terminal, input_terminal};
        state_next.sync2   = state_reg.sync1;
        state_next.sync3   = state_reg.sync2;
        state_next.level_d = state_reg.level;
        for (int i = 0; i <= NUM_TERMS; i++)
        begin
            if (state_reg.sync2[i] == state_reg.sync3[i])
                state_next.level[i] = state_reg.sync3[i];
        end

        ovr = func[F_OVERRIDE];
        if (func[F_REMOTE])
        begin
            if (func[F_FWD_LATCH] && !func[F_REV_LATCH] && !func[F_PERMIT_N])
            begin
                state_next.latch_run = 1'b1;
                state_next.latch_rev = 1'b0;
            end
            else if (func[F_REV_LATCH] && !func[F_FWD_LATCH] && !func[F_PERMIT_N])
            begin
                state_next.latch_run = 1'b1;
                state_next.latch_rev = 1'b1;
            end
        end
        if (func[F_PERMIT_N]) state_next.latch_run = 1'b0;
        if (func[F_INCH_FWD] || func[F_INCH_REV]) state_next.latch_run = 1'b0;
        // Drive commands leave through a register
        state_next.cmd = cmd_comb;

        if (func[F_REF_UP] && !func[F_REF_DOWN] && state_reg.console_ref != 16'hFFFF)
            state_next.console_ref = state_reg.console_ref + 16'h0001;
        else if (func[F_REF_DOWN] && !func[F_REF_UP] && state_reg.console_ref != 16'h0000)
            state_next.console_ref = state_reg.console_ref - 16'h0001;

        // Bus slave: two wait cycles, then answer
        bus_req  = avs_read || avs_write;
        bus_wr   = 1'b0;
        map_hit  = avs_address >= `REG_MAP_BASE && avs_address < (`REG_MAP_BASE + 8'h30);
        map_idx  = 4'((avs_address - `REG_MAP_BASE) >> 2);
        wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        case (state_reg.bus)
            BUS_IDLE: if (bus_req) state_next.bus = BUS_WAIT;
            BUS_WAIT:
            begin
                state_next.bus   = BUS_DONE;
                state_next.resp  = 2'h0;
                state_next.rdata = 32'h0000_0000;
                case (avs_address)
                    `REG_PROFILE:  state_next.rdata = {29'h0, state_reg.profile};
                    `REG_SETTINGS: state_next.rdata = {state_reg.ovr_ramp, 13'h0,
                                       state_reg.con_rev, state_reg.con_run, state_reg.rev_perm};
                    `REG_STATUS:   state_next.rdata = {15'h0, state_reg.level,
                                       func[11:4], state_reg.latch_run, state_reg.latch_rev,
                                       ovr, 1'b0};
                    `REG_CONSOLE:  state_next.rdata = {16'h0, state_reg.console_ref};
                    `REG_RAMP:     state_next.rdata = {16'h0, state_reg.ramp};
                    `REG_RESTART:  state_next.rdata = {24'h0, state_reg.restart};
                    default:
                    begin
                        if (map_hit && state_reg.profile == PROF_CUSTOM)
                            state_next.rdata = {27'h0, state_reg.map[map_idx]};
                        else
                            state_next.resp = 2'h2;
                    end
                endcase
            end
            // Write lands on the edge that sees waitrequest low
            BUS_DONE:
            begin
                state_next.bus = BUS_IDLE;
                bus_wr = avs_write;
                if (bus_wr)
                begin
                    case (avs_address)
                        `REG_PROFILE:
                            if (avs_byteenable[0]) state_next.profile = profile_t'(avs_writedata[2:0]);
                        `REG_SETTINGS:
                        begin
                            if (avs_byteenable[0])
                            begin
                                state_next.rev_perm = avs_writedata[`SET_REVPERM_BIT];
                                state_next.con_run  = avs_writedata[`SET_CONRUN_BIT];
                                state_next.con_rev  = avs_writedata[`SET_CONREV_BIT];
                            end
                            state_next.ovr_ramp = (avs_writedata[31:16] & wmask[31:16])
                                | (state_reg.ovr_ramp & ~wmask[31:16]);
                        end
                        `REG_CONSOLE:
                            state_next.console_ref = (avs_writedata[15:0] & wmask[15:0])
                                | (state_reg.console_ref & ~wmask[15:0]);
                        `REG_RAMP:
                            if (!ovr) state_next.ramp = (avs_writedata[15:0] & wmask[15:0])
                                | (state_reg.ramp & ~wmask[15:0]);
                        `REG_RESTART:
                            if (!ovr && avs_byteenable[0]) state_next.restart = avs_writedata[7:0];
                        default:
                            if (map_hit && state_reg.profile == PROF_CUSTOM && avs_byteenable[0])
                            begin
                                state_next.map[map_idx] = avs_writedata[4:0];
                            end
                    endcase
                end
            end
            default:  state_next.bus = BUS_IDLE;
        endcase
    end

    // Bus handshake outputs
    always_comb
    begin
        avs_waitrequest = !(state_reg.bus == BUS_DONE);
        avs_readdata    = state_reg.rdata;
        avs_response    = state_reg.resp;
        drive_cmd       = state_reg.cmd;
    end

    // Run arbitration
    always_comb
    begin
        // Remote path uses terminal commands
        // held runs, permit ignored
        fwd_req = func[F_FWD_HELD] || (state_reg.latch_run && !state_reg.latch_rev);
        rev_req = func[F_REV_HELD] || (state_reg.latch_run && state_reg.latch_rev);
        if (!func[F_REMOTE])
        begin
            fwd_req = state_reg.con_run && !state_reg.con_rev;
            rev_req = state_reg.con_run && state_reg.con_rev;
        end
        inch = func[F_INCH_FWD] ^ func[F_INCH_REV];
        if (func[F_INCH_FWD] || func[F_INCH_REV])
        begin
            fwd_req = func[F_INCH_FWD];
            rev_req = func[F_INCH_REV];
        end
        if (!state_reg.rev_perm) rev_req = 1'b0;
        cmd_comb = '0;
        cmd_comb.run     = fwd_req ^ rev_req;
        cmd_comb.reverse = rev_req && !fwd_req;
        // Inching flagged only while it moves the motor
        cmd_comb.inching = inch && (fwd_req ^ rev_req);
        if (ovr)
        begin
            cmd_comb.run     = 1'b1;
            cmd_comb.reverse = 1'b0;
            cmd_comb.inching = 1'b0;
        end
        cmd_comb.override_mode = ovr;
        cmd_comb.remote_ref = func[F_REMOTE];
        cmd_comb.trip_clear = func[F_TRIP_CLR];
        cmd_comb.ref_up     = func[F_REF_UP];
        cmd_comb.ref_down   = func[F_REF_DOWN];
        cmd_comb.trip_mask         = ovr;
        cmd_comb.restart_unlimited = ovr;
        cmd_comb.ramp_s = ovr ? state_reg.ovr_ramp : state_reg.ramp;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg          <= '0;
            state_reg.profile  <= profile_t'(`PROFILE_RESET);
            state_reg.ramp     <= `RAMP_RESET_S;
            state_reg.cmd.ramp_s <= `RAMP_RESET_S;
            state_reg.ovr_ramp <= `OVR_RAMP_RESET;
            state_reg.restart  <= `RESTART_RESET;
            state_reg.bus      <= BUS_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule : drive_run_command_inputs
`default_nettype wire

// ---- sim/contact_strip.sv ----
// Switch contact model for the drive input terminal strip
`default_nettype none
module contact_strip
(
    input  wire logic [4:0] closed,          // Contacts closed: t1..t4, enable
    output logic      [3:0] input_terminal,  // Terminal levels seen by the drive
    output logic            enable_terminal  // Enable terminal level
);
    timeunit 1ns;
    timeprecision 1ns;
    // An open contact sits at the pull-down level
    assign input_terminal  = closed[3:0];
    assign enable_terminal = closed[4];
endmodule : contact_strip
`default_nettype wire

// ---- sim/drive_inputs_sva.sv ----
// Checker for bus timing and drive commands of the routing block
`default_nettype none
module drive_inputs_sva
    import drive_inputs_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] avs_address,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire drive_cmd_t drive_cmd
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // New request seen while idle
    sequence take_s;
        $rose(avs_read || avs_write);
    endsequence
    // Two wait states, then the answer
    sequence answer_s;
        avs_waitrequest[*2] ##1 !avs_waitrequest;
    endsequence
    wait_answer_a: assert property (take_s |-> answer_s)
        else $error("bus answer not two cycles after request");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
        else $error("waitrequest low with no request");
    unmapped_err_a: assert property (!avs_waitrequest && avs_address inside {[8'h18:8'h3C]}
        |-> avs_response == 2'h2) else $error("unmapped access not refused");
    status_ok_a: assert property (!avs_waitrequest && avs_read && avs_address == 8'h08
        |-> avs_response == 2'h0) else $error("status read refused");
    override_run_a: assert property (drive_cmd.override_mode |-> drive_cmd.run)
        else $error("override without run");
    override_mask_a: assert property (drive_cmd.override_mode |->
        drive_cmd.trip_mask && drive_cmd.restart_unlimited) else $error("override trips");
    inch_run_a: assert property (drive_cmd.inching && !drive_cmd.reverse |-> drive_cmd.run)
        else $error("inching without run");
endmodule : drive_inputs_sva
bind drive_run_command_inputs drive_inputs_sva chk (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the drive terminal input routing block
`default_nettype none
module testbench
    import drive_inputs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys         = 1'b0;
    logic        rst_n           = 1'b0;
    logic [4:0]  closed          = 5'h00;  // Contacts: t1..t4, enable
    logic [3:0]  input_terminal;
    logic        enable_terminal;
    logic [7:0]  avs_address     = 8'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [3:0]  avs_byteenable  = 4'hF;   // Whole words only
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    drive_cmd_t  drive_cmd;
    logic [31:0] rdata;                    // Last read data
    logic [1:0]  rresp;                    // Last response code
    int          bad_count       = 0;
    int          tests_run       = 0;
    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;
    contact_strip strip (.*);
    drive_run_command_inputs uut (.*);
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask : check
    // One bus transfer, held until waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        rdata = avs_readdata;
        rresp = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 40)
            bad_count++;
        @(posedge clk_sys);
    endtask : bus
    // Set contacts and let the synchroniser settle
    task automatic terms(input logic [4:0] v);
        closed <= v;
        repeat (8) @(posedge clk_sys);
    endtask : terms
    task automatic test_reset;
        check(drive_cmd.ramp_s, 16'h000A);
        check(drive_cmd.run, 1'b0);
        bus(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        check(rdata, 32'h000A0000);
        bus(1'b0, 8'h08, 32'h0);
        check(rresp, 2'h0);
        bus(1'b0, 8'h20, 32'h0);
        check(rresp, 2'h2);
        bus(1'b1, 8'h44, 32'h1);
        check(rresp, 2'h2);
    endtask : test_reset
    task automatic test_latch;
        terms(5'h08);
        check(drive_cmd.remote_ref, 1'b1);
        terms(5'h0C);
        terms(5'h08);
        check({drive_cmd.run, drive_cmd.reverse}, 2'b10);
        terms(5'h0A);
        check(drive_cmd.run, 1'b0);
        terms(5'h00);
        check(drive_cmd.remote_ref, 1'b0);
    endtask : test_latch
    task automatic test_rev_latch;
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b1, 8'h04, 32'h000A0001);
        terms(5'h08);
        terms(5'h0C);
        terms(5'h08);
        check({drive_cmd.run, drive_cmd.reverse}, 2'b11);
        terms(5'h09);
        check(drive_cmd.run, 1'b0);
    endtask : test_rev_latch
    task automatic test_held;
        bus(1'b1, 8'h00, 32'h5);
        bus(1'b1, 8'h04, 32'h000A0000);
        terms(5'h12);
        check(drive_cmd.reverse, 1'b0);
        terms(5'h18);
        check({drive_cmd.inching, drive_cmd.run}, 2'b00);
        bus(1'b1, 8'h04, 32'h000A0001);
        terms(5'h11);
        check({drive_cmd.run, drive_cmd.reverse}, 2'b10);
        terms(5'h12);
        check({drive_cmd.run, drive_cmd.reverse}, 2'b11);
        terms(5'h13);
        check(drive_cmd.run, 1'b0);
        terms(5'h14);
        check({drive_cmd.inching, drive_cmd.run}, 2'b11);
        terms(5'h10);
        check(drive_cmd.run, 1'b0);
        terms(5'h18);
        check({drive_cmd.inching, drive_cmd.run, drive_cmd.reverse}, 3'b111);
    endtask : test_held
    task automatic test_override;
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h04, 32'h00070001);
        check(drive_cmd.ramp_s, 16'h000A);
        terms(5'h04);
        check({drive_cmd.override_mode, drive_cmd.run}, 2'b11);
        check(drive_cmd.ramp_s, 16'h0007);
        bus(1'b1, 8'h10, 32'h5);
        bus(1'b0, 8'h10, 32'h0);
        check(rdata, 32'hA);
        terms(5'h10);
        check(drive_cmd.trip_clear, 1'b1);
    endtask : test_override
    task automatic test_custom;
        bus(1'b1, 8'h00, 32'h7);
        bus(1'b1, 8'h54, 32'h01);
        bus(1'b0, 8'h54, 32'h0);
        check(rdata, 32'h01);
        bus(1'b1, 8'h58, 32'h0A);
        bus(1'b1, 8'h48, 32'h06);
        bus(1'b1, 8'h4C, 32'h01);
        bus(1'b1, 8'h6C, 32'h06);
        terms(5'h00);
        check({drive_cmd.ref_up, drive_cmd.ref_down}, 2'b01);
        terms(5'h01);
        check({drive_cmd.ref_up, drive_cmd.ref_down}, 2'b11);
        check(drive_cmd.run, 1'b1);
    endtask : test_custom
    // Verdict and end of run
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_latch();
        test_rev_latch();
        test_held();
        test_override();
        test_custom();
        complete_run();
    end
    // Watchdog, far beyond the expected run of some 280 cycles
    initial
    begin
        #800000;
        bad_count++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
